//--- gcr_pkg.sv
// shared constants and types for the global switch control registers
package gcr_pkg;
  // register offsets on the management register port
  localparam logic [7:0] LED_CLOCK_SPI_CONTROL_OFS = 8'h0b;
  localparam logic [7:0] TAIL_TAG_FLOW_CTL_OFS     = 8'h0c;
  localparam logic [7:0] FACTORY_TEST_B_OFS        = 8'h0d;
  localparam logic [7:0] POWER_MODE_CONTROL_OFS    = 8'h0e;
  localparam logic [7:0] SLEEP_ENTRY_DELAY_OFS     = 8'h0f;

  // field positions
  localparam int LED_MODE_LSB    = 4;
  localparam int REFCLK_EN_BIT   = 1;
  localparam int SPI_EDGE_BIT    = 0;
  localparam int TAIL_TAG_BIT    = 1;
  localparam int PASS_FC_BIT     = 0;
  localparam int TT_FIXED_LSB    = 2;
  localparam int PLL_PD_BIT      = 5;
  localparam int PM_MODE_LSB     = 3;

  // reset and fixed values
  localparam logic [1:0] LED_MODE_RST    = 2'h0;
  localparam logic [3:0] TT_FIXED_VAL    = 4'h1;
  localparam logic [7:0] FACTORY_B_VAL   = 8'h00;
  localparam logic [7:0] SLEEP_DELAY_RST = 8'h50;
  localparam logic [7:0] UNMAPPED_VAL    = 8'h00;

  // timing: clock rate, sleep unit and activity blink half period
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned SLEEP_UNIT_MS    = 20;
  localparam int unsigned SLEEP_UNIT_CYC   = SLEEP_UNIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLINK_MS         = 50;
  localparam int unsigned BLINK_CYC        = BLINK_MS * 1000 * CLK_MHZ;
  localparam int unsigned REFCLK_MHZ       = 25;
  localparam int unsigned REFCLK_DIV       = CLK_MHZ / REFCLK_MHZ;

  // second port led function
  typedef enum logic [1:0] {
    LED_SPEED  = 2'b00,
    LED_ACT    = 2'b01,
    LED_DUPLEX = 2'b10,
    LED_DUP2   = 2'b11
  } gcr_led_mode_t;

  // power management mode
  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_ENERGY = 2'b01,
    PM_SOFTPD = 2'b10,
    PM_RSVD   = 2'b11
  } gcr_pm_mode_t;

  // sleep state of the energy detect logic
  typedef enum logic [0:0] {
    SLP_AWAKE  = 1'b0,
    SLP_ASLEEP = 1'b1
  } gcr_sleep_t;

  // per port status from the mac/phy
  typedef struct packed {
    logic link;
    logic activity;
    logic speed100;
    logic full_duplex;
  } gcr_port_stat_t;

  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gcr_reg_req_t;
endpackage : gcr_pkg

//--- gcr_global_ctl.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - bits 5-4 pick second led function
// - speed led on 100, off 10
// - duplex led on full, off half
// - bit 1 gates 25 MHz clock out
// - clock out enable resets from strap
// - bit 0 picks spi read sample edge
// - tail tag adds byte, port 4 only
// - pass bit forwards pause frames
// - pll down only in energy detect
// - bits 4-3 pick power state
// - sleep after delay times 20 ms quiet
// - sleep delay resets to 80
// - tail tag bits 5-2 read 0001
module gcr_global_ctl #(
  parameter int unsigned NUM_PORTS         = 4,
  parameter int unsigned SLEEP_UNIT_CYCLES = gcr_pkg::SLEEP_UNIT_CYC,
  parameter int unsigned BLINK_CYCLES      = gcr_pkg::BLINK_CYC
) (
  // clock and reset
  input  wire logic                                  mclk,
  input  wire logic                                  reset_n,
  // register port
  input  wire gcr_pkg::gcr_reg_req_t                 reg_req,
  output logic [7:0]                                 reg_rdata,
  // strap and port status
  input  wire logic                                  led_strap_pin,
  input  wire gcr_pkg::gcr_port_stat_t [NUM_PORTS-1:0] port_stat,
  input  wire logic                                  energy_seen,
  // leds, active low
  output logic [NUM_PORTS-1:0]                       second_port_led_n,
  // clock out
  output logic                                       ref_clock_out_pin,
  // configuration to the switch core
  output logic                                       spi_sample_rising,
  output logic                                       tail_tag_port4_en,
  output logic                                       pass_flow_ctl,
  // power management
  output gcr_pkg::gcr_pm_mode_t                      power_mode,
  output logic                                       low_power_state,
  output logic                                       pll_power_down
);
  // configuration registers
  logic [1:0] led_mode_reg, led_mode_next;   // second led function
  logic       refclk_en_reg, refclk_en_next; // clock out enable
  logic       spi_edge_reg, spi_edge_next;   // spi sample edge
  logic       tail_tag_reg, tail_tag_next;   // port 4 tail tag
  logic       pass_fc_reg, pass_fc_next;     // forward pause frames
  logic       pll_pd_reg, pll_pd_next;       // pll power-down enable
  logic [1:0] pm_mode_reg, pm_mode_next;     // power mode
  logic [7:0] delay_reg, delay_next;         // sleep entry delay
  logic [7:0] rdata_reg, rdata_next;         // read data

  // register write and read
  always_comb
  begin
    led_mode_next  = led_mode_reg;
    refclk_en_next = refclk_en_reg;
    spi_edge_next  = spi_edge_reg;
    tail_tag_next  = tail_tag_reg;
    pass_fc_next   = pass_fc_reg;
    pll_pd_next    = pll_pd_reg;
    pm_mode_next   = pm_mode_reg;
    delay_next     = delay_reg;
    rdata_next     = rdata_reg;
    if (reg_req.wr)
    begin
      // reserved bits are dropped on write
      case (reg_req.addr)
        gcr_pkg::LED_CLOCK_SPI_CONTROL_OFS:
        begin
          led_mode_next  = reg_req.wdata[gcr_pkg::LED_MODE_LSB +: 2];
          refclk_en_next = reg_req.wdata[gcr_pkg::REFCLK_EN_BIT];
          spi_edge_next  = reg_req.wdata[gcr_pkg::SPI_EDGE_BIT];
        end
        gcr_pkg::TAIL_TAG_FLOW_CTL_OFS:
        begin
          tail_tag_next = reg_req.wdata[gcr_pkg::TAIL_TAG_BIT];
          pass_fc_next  = reg_req.wdata[gcr_pkg::PASS_FC_BIT];
        end
        gcr_pkg::POWER_MODE_CONTROL_OFS:
        begin
          pll_pd_next  = reg_req.wdata[gcr_pkg::PLL_PD_BIT];
          pm_mode_next = reg_req.wdata[gcr_pkg::PM_MODE_LSB +: 2];
        end
        gcr_pkg::SLEEP_ENTRY_DELAY_OFS: delay_next = reg_req.wdata;
        default: ; // unmapped and read-only offsets ignore writes
      endcase
    end
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        gcr_pkg::LED_CLOCK_SPI_CONTROL_OFS:
          rdata_next = {2'h0, led_mode_reg, 2'h0, refclk_en_reg, spi_edge_reg};
        gcr_pkg::TAIL_TAG_FLOW_CTL_OFS:
          rdata_next = {2'h0, gcr_pkg::TT_FIXED_VAL, tail_tag_reg, pass_fc_reg};
        gcr_pkg::FACTORY_TEST_B_OFS:  rdata_next = gcr_pkg::FACTORY_B_VAL;
        gcr_pkg::POWER_MODE_CONTROL_OFS:
          rdata_next = {2'h0, pll_pd_reg, pm_mode_reg, 3'h0};
        gcr_pkg::SLEEP_ENTRY_DELAY_OFS: rdata_next = delay_reg;
        default: rdata_next = gcr_pkg::UNMAPPED_VAL;
      endcase
    end
  end

  // register bank flops; strap is sampled while reset is held
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      led_mode_reg  <= gcr_pkg::LED_MODE_RST;
      refclk_en_reg <= led_strap_pin;         // sync reset, so a clocked strap capture
      spi_edge_reg  <= 1'b0;
      tail_tag_reg  <= 1'b0;
      pass_fc_reg   <= 1'b0;
      pll_pd_reg    <= 1'b0;
      pm_mode_reg   <= gcr_pkg::PM_NORMAL;
      delay_reg     <= gcr_pkg::SLEEP_DELAY_RST;
      rdata_reg     <= gcr_pkg::UNMAPPED_VAL;
    end
    else
    begin
      led_mode_reg  <= led_mode_next;
      refclk_en_reg <= refclk_en_next;
      spi_edge_reg  <= spi_edge_next;
      tail_tag_reg  <= tail_tag_next;
      pass_fc_reg   <= pass_fc_next;
      pll_pd_reg    <= pll_pd_next;
      pm_mode_reg   <= pm_mode_next;
      delay_reg     <= delay_next;
      rdata_reg     <= rdata_next;
    end
  end

  // blink phase and led drive
  logic [31:0]          blink_cnt_reg, blink_cnt_next; // blink half period counter
  logic                 blink_reg, blink_next;         // blink phase
  logic [NUM_PORTS-1:0] led_n_reg, led_n_next;         // led pins, low = lit
  logic [1:0]           div_reg, div_next;             // 25 MHz divider
  logic                 refclk_reg, refclk_next;       // clock out flop
  always_comb
  begin
    blink_cnt_next = blink_cnt_reg + 32'h1;
    blink_next     = blink_reg;
    if (blink_cnt_reg >= 32'(BLINK_CYCLES - 1))
    begin
      blink_cnt_next = 32'h0;
      blink_next     = ~blink_reg;
    end
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      case (gcr_pkg::gcr_led_mode_t'(led_mode_reg))
        gcr_pkg::LED_SPEED:  led_n_next[i] = ~(port_stat[i].link & port_stat[i].speed100);
        gcr_pkg::LED_ACT:    led_n_next[i] = ~(port_stat[i].link & ~(port_stat[i].activity & blink_reg));
        default:             led_n_next[i] = ~(port_stat[i].link & port_stat[i].full_duplex);
      endcase
    end
    // divider stops at zero so the pin idles low when disabled
    div_next    = refclk_en_reg ? div_reg + 2'h1 : 2'h0;
    refclk_next = refclk_en_reg & div_reg[1];
  end
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= 1'b0;
      led_n_reg     <= '1;
      div_reg       <= 2'h0;
      refclk_reg    <= 1'b0;
    end
    else
    begin
      blink_cnt_reg <= blink_cnt_next;
      blink_reg     <= blink_next;
      led_n_reg     <= led_n_next;
      div_reg       <= div_next;
      refclk_reg    <= refclk_next;
    end
  end

  // energy detect sleep timer
  gcr_pkg::gcr_sleep_t sleep_reg, sleep_next; // sleep state
  logic [31:0]         unit_cnt_reg, unit_cnt_next; // cycles inside a 20 ms unit
  logic [7:0]          units_reg, units_next;       // quiet units seen, saturating
  logic                pll_off_reg, pll_off_next;   // pll shut down
  logic                ed_quiet;                    // energy mode with no energy
  always_comb
  begin
    ed_quiet      = (pm_mode_reg == gcr_pkg::PM_ENERGY) && !energy_seen;
    unit_cnt_next = 32'h0;
    units_next    = 8'h0;
    sleep_next    = gcr_pkg::SLP_AWAKE;
    if (ed_quiet)
    begin
      // any energy restarts the wait, so quiet must be continuous
      unit_cnt_next = unit_cnt_reg + 32'h1;
      units_next    = units_reg;
      if (unit_cnt_reg >= 32'(SLEEP_UNIT_CYCLES - 1))
      begin
        unit_cnt_next = 32'h0;
        if (units_reg != 8'hff)
          units_next = units_reg + 8'h1;
      end
      if (units_reg >= delay_reg)
        sleep_next = gcr_pkg::SLP_ASLEEP;
    end
    pll_off_next = pll_pd_reg && (sleep_next == gcr_pkg::SLP_ASLEEP);
  end
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      sleep_reg    <= gcr_pkg::SLP_AWAKE;
      unit_cnt_reg <= 32'h0;
      units_reg    <= 8'h0;
      pll_off_reg  <= 1'b0;
    end
    else
    begin
      sleep_reg    <= sleep_next;
      unit_cnt_reg <= unit_cnt_next;
      units_reg    <= units_next;
      pll_off_reg  <= pll_off_next;
    end
  end

  // outputs
  assign reg_rdata         = rdata_reg;
  assign second_port_led_n = led_n_reg;
  assign ref_clock_out_pin = refclk_reg;
  assign spi_sample_rising = spi_edge_reg;
  assign tail_tag_port4_en = tail_tag_reg;
  assign pass_flow_ctl     = pass_fc_reg;
  assign power_mode        = gcr_pkg::gcr_pm_mode_t'(pm_mode_reg);
  assign low_power_state   = (sleep_reg == gcr_pkg::SLP_ASLEEP);
  assign pll_power_down    = pll_off_reg;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_led_speed;
    (led_mode_reg == 2'b00) |=> (led_n_reg[0] == !$past(port_stat[0].link & port_stat[0].speed100));
  endproperty
  a_led_speed: assert property (p_led_speed) else $error("speed led wrong");
  property p_led_duplex;
    led_mode_reg[1] |=> (led_n_reg[0] == !$past(port_stat[0].link & port_stat[0].full_duplex));
  endproperty
  a_led_duplex: assert property (p_led_duplex) else $error("duplex led wrong");
  property p_led_act_nolink;
    (led_mode_reg == 2'b01 && !port_stat[0].link) |=> led_n_reg[0];
  endproperty
  a_led_act_nolink: assert property (p_led_act_nolink) else $error("act led lit without link");
  property p_refclk_off;
    !refclk_en_reg |=> !ref_clock_out_pin;
  endproperty
  a_refclk_off: assert property (p_refclk_off) else $error("clock out while disabled");
  property p_refclk_div;
    refclk_en_reg [*4] |=> (ref_clock_out_pin != $past(ref_clock_out_pin, 2));
  endproperty
  a_refclk_div: assert property (p_refclk_div) else $error("clock out not divide by four");
  // reset checks run while reset is held, so they opt out of the default disable
  property p_strap;
    @(posedge mclk) disable iff (1'b0) !reset_n |=> (refclk_en_reg == $past(led_strap_pin));
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured");
  property p_sleep_cause;
    $rose(low_power_state) |-> $past(ed_quiet) && ($past(units_reg) >= $past(delay_reg));
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep without quiet period");
  property p_pll_gate;
    pll_power_down |-> low_power_state && $past(pll_pd_reg) && ($past(power_mode) == gcr_pkg::PM_ENERGY);
  endproperty
  a_pll_gate: assert property (p_pll_gate) else $error("pll down outside energy detect");
  property p_tt_fixed;
    (reg_req.rd && reg_req.addr == gcr_pkg::TAIL_TAG_FLOW_CTL_OFS) |=> (reg_rdata[7:2] == 6'h01);
  endproperty
  a_tt_fixed: assert property (p_tt_fixed) else $error("tail tag fixed bits wrong");
  property p_delay_reset;
    @(posedge mclk) disable iff (1'b0) !reset_n |=> (delay_reg == 8'h50);
  endproperty
  a_delay_reset: assert property (p_delay_reset) else $error("sleep delay reset wrong");
  property p_factory_ro;
    (reg_req.rd && reg_req.addr == gcr_pkg::FACTORY_TEST_B_OFS) |=> (reg_rdata == 8'h00);
  endproperty
  a_factory_ro: assert property (p_factory_ro) else $error("factory register not zero");

  c_sleep:  cover property ($rose(low_power_state));
  c_pll:    cover property ($rose(pll_power_down));
  c_refclk: cover property ($rose(ref_clock_out_pin));
  c_wake:   cover property ($fell(low_power_state));
endmodule : gcr_global_ctl
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // short sleep unit and blink phase so the run stays brief
  localparam int unsigned UNIT  = 10;
  localparam int unsigned LIMIT = 5000;

  logic                          mclk;
  logic                          reset_n;
  gcr_pkg::gcr_reg_req_t         req;
  logic [7:0]                    rdata;
  logic                          strap;
  gcr_pkg::gcr_port_stat_t [3:0] stat;
  logic                          energy;
  logic [3:0]                    led_n;
  logic                          refclk;
  logic                          spi_rise;
  logic                          tail_en;
  logic                          pass_fc;
  gcr_pkg::gcr_pm_mode_t         pm;
  logic                          low_pwr;
  logic                          pll_pd;
  int                            errors;
  int                            n_checks;
  int                            cycles;

  // device under test with shortened counts
  gcr_global_ctl #(.NUM_PORTS(4), .SLEEP_UNIT_CYCLES(UNIT), .BLINK_CYCLES(4)) i_dut (
    .mclk              (mclk),
    .reset_n           (reset_n),
    .reg_req           (req),
    .reg_rdata         (rdata),
    .led_strap_pin     (strap),
    .port_stat         (stat),
    .energy_seen       (energy),
    .second_port_led_n (led_n),
    .ref_clock_out_pin (refclk),
    .spi_sample_rising (spi_rise),
    .tail_tag_port4_en (tail_en),
    .pass_flow_ctl     (pass_fc),
    .power_mode        (pm),
    .low_power_state   (low_pwr),
    .pll_power_down    (pll_pd)
  );

  // free running 100 mhz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // hang guard, far above the expected run length
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      final_report();
    end
  end

  // one comparison of any value up to a byte
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one-cycle write strobe
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
  endtask : reg_wr

  // one-cycle read strobe, data judged once it has landed
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
    #1;
    check(rdata, exp);
  endtask : reg_rd

  // settle a few edges, then sit just past the edge
  task automatic waitc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : waitc

  // reset held for eight edges with a chosen strap level
  task automatic do_reset(input logic s);
    @(posedge mclk);
    strap   <= s;
    reset_n <= 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
  endtask : do_reset

  // counts high samples of the clock output over eight cycles
  task automatic refclk_ones(input logic [7:0] exp);
    logic [7:0] s;
    for (int i = 0; i < 8; i++)
    begin
      s[i] = refclk;
      waitc(1);
    end
    check(8'($countones(s)), exp);
    if (exp != 8'h00)
      check({7'h00, s[0] ^ s[2]}, 8'h01);
  endtask : refclk_ones

  // reset values of every register plus an unmapped read
  task automatic t_reset_vals();
    reg_rd(gcr_pkg::LED_CLOCK_SPI_CONTROL_OFS, 8'h02);
    reg_rd(gcr_pkg::TAIL_TAG_FLOW_CTL_OFS, 8'h04);
    reg_rd(gcr_pkg::FACTORY_TEST_B_OFS, 8'h00);
    reg_rd(gcr_pkg::POWER_MODE_CONTROL_OFS, 8'h00);
    reg_rd(gcr_pkg::SLEEP_ENTRY_DELAY_OFS, 8'h50);
    reg_rd(8'h3a, 8'h00);
    refclk_ones(8'h04);
  endtask : t_reset_vals

  // all ones written to led, tail tag, factory and an unmapped offset, 8'hd8 to power mode; reserved bits must hold
  task automatic t_access();
    reg_wr(gcr_pkg::LED_CLOCK_SPI_CONTROL_OFS, 8'hff);
    reg_wr(gcr_pkg::TAIL_TAG_FLOW_CTL_OFS, 8'hff);
    reg_wr(gcr_pkg::FACTORY_TEST_B_OFS, 8'hff);
    reg_wr(gcr_pkg::POWER_MODE_CONTROL_OFS, 8'hd8);
    reg_wr(8'h3a, 8'hff);
    reg_rd(gcr_pkg::LED_CLOCK_SPI_CONTROL_OFS, 8'h33);
    reg_rd(gcr_pkg::TAIL_TAG_FLOW_CTL_OFS, 8'h07);
    reg_rd(gcr_pkg::FACTORY_TEST_B_OFS, 8'h00);
    reg_rd(gcr_pkg::POWER_MODE_CONTROL_OFS, 8'h18);
    reg_rd(8'h3a, 8'h00);
    check({7'h00, spi_rise}, 8'h01);
    check({6'h00, tail_en, pass_fc}, 8'h03);
    check({6'h00, pm}, 8'h03);
    reg_wr(gcr_pkg::TAIL_TAG_FLOW_CTL_OFS, 8'h00);
    reg_wr(gcr_pkg::POWER_MODE_CONTROL_OFS, 8'h10);
    waitc(2);
    check({6'h00, tail_en, pass_fc}, 8'h00);
    check({6'h00, pm}, 8'h02);
  endtask : t_access

  // every led code against a mix of port states, no activity
  task automatic t_leds();
    logic [3:0] lit [4];
    logic [7:0] s;
    lit = '{4'b1001, 4'b1011, 4'b1010, 4'b1010};
    @(posedge mclk);
    stat[0] <= '{link: 1'b1, activity: 1'b0, speed100: 1'b1, full_duplex: 1'b0};
    stat[1] <= '{link: 1'b1, activity: 1'b0, speed100: 1'b0, full_duplex: 1'b1};
    stat[2] <= '{link: 1'b0, activity: 1'b0, speed100: 1'b1, full_duplex: 1'b1};
    stat[3] <= '{link: 1'b1, activity: 1'b0, speed100: 1'b1, full_duplex: 1'b1};
    for (int m = 0; m < 4; m++)
    begin
      reg_wr(gcr_pkg::LED_CLOCK_SPI_CONTROL_OFS, {2'b00, 2'(m), 4'h0});
      waitc(3);
      check({4'h0, led_n}, {4'h0, ~lit[m]});
    end
    // activity blinks a linked port half the time; a dropped link stays dark
    @(posedge mclk);
    stat[0] <= '{link: 1'b1, activity: 1'b1, speed100: 1'b1, full_duplex: 1'b0};
    reg_wr(gcr_pkg::LED_CLOCK_SPI_CONTROL_OFS, 8'h10);
    waitc(3);
    for (int i = 0; i < 8; i++)
    begin
      s[i] = led_n[0];
      waitc(1);
    end
    check(8'($countones(s)), 8'h04);
    @(posedge mclk);
    stat[0] <= '{link: 1'b0, activity: 1'b1, speed100: 1'b1, full_duplex: 1'b0};
    waitc(3);
    check({7'h00, led_n[0]}, 8'h01);
  endtask : t_leds

  // clock output switched on and off by software
  task automatic t_refclk();
    reg_wr(gcr_pkg::LED_CLOCK_SPI_CONTROL_OFS, 8'h02);
    waitc(4);
    refclk_ones(8'h04);
    reg_wr(gcr_pkg::LED_CLOCK_SPI_CONTROL_OFS, 8'h00);
    waitc(2);
    refclk_ones(8'h00);
  endtask : t_refclk

  // quiet line: no sleep in normal mode, timed sleep in energy mode
  task automatic t_sleep();
    int cnt;
    reg_wr(gcr_pkg::SLEEP_ENTRY_DELAY_OFS, 8'h03);
    reg_wr(gcr_pkg::POWER_MODE_CONTROL_OFS, 8'h20);
    @(posedge mclk);
    energy <= 1'b0;
    waitc(60);
    check({6'h00, low_pwr, pll_pd}, 8'h00);
    reg_wr(gcr_pkg::POWER_MODE_CONTROL_OFS, 8'h28);
    cnt = 0;
    while (low_pwr !== 1'b1 && cnt < 200)
    begin
      waitc(1);
      cnt++;
    end
    check({7'h00, cnt >= 26 && cnt <= 36}, 8'h01);
    check({7'h00, pll_pd}, 8'h01);
    @(posedge mclk);
    energy <= 1'b1;
    waitc(3);
    check({6'h00, low_pwr, pll_pd}, 8'h00);
    // pll bit clear: sleep still comes, pll stays up
    reg_wr(gcr_pkg::POWER_MODE_CONTROL_OFS, 8'h08);
    @(posedge mclk);
    energy <= 1'b0;
    waitc(45);
    check({6'h00, low_pwr, pll_pd}, 8'h02);
    @(posedge mclk);
    energy <= 1'b1;
  endtask : t_sleep

  // second reset with the strap pulled down
  task automatic t_strap_low();
    do_reset(1'b0);
    reg_rd(gcr_pkg::LED_CLOCK_SPI_CONTROL_OFS, 8'h00);
    reg_rd(gcr_pkg::SLEEP_ENTRY_DELAY_OFS, 8'h50);
    refclk_ones(8'h00);
    check({7'h00, spi_rise}, 8'h00);
  endtask : t_strap_low

  // counts, verdict and end of run
  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // main sequence
  initial
  begin
    reset_n  = 1'b0;
    req      = '0;
    strap    = 1'b1;
    stat     = '0;
    energy   = 1'b1;
    errors   = 0;
    n_checks = 0;
    cycles   = 0;
    do_reset(1'b1);
    t_reset_vals();
    t_access();
    t_leds();
    t_refclk();
    t_sleep();
    t_strap_low();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
